// ==== core/aid_identify_responder.sv ====
// identify device command responder behind an avalon-mm task file
`include "aid_map.svh"

module aid_identify_responder #(
   parameter logic [15:0]  DEF_CYLS      = 16'h3fff,
   parameter logic [15:0]  DEF_HEADS     = 16'h0010,
   parameter logic [31:0]  TOTAL_SECTORS = 32'h00fb_fc10,
   parameter logic         DRIVE_NUM     = 1'b0,
   parameter logic [159:0] SERIAL_STR    = 160'h0,
   parameter logic [63:0]  FW_STR        = "FW 1.00 ",
   parameter logic [319:0] MODEL_STR     = "GENERIC IDENTIFY DISK                   "
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // avalon-mm slave
   input  wire logic [5:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output      logic [31:0] readdata,
   output      logic        waitrequest
);

   logic                  rstMeta;
   logic                  rstSync;
   aid_pkg::aid_state_t   state;
   aid_pkg::aid_taskfile_t taskFile;
   aid_pkg::aid_cfg_t     cfg;
   aid_pkg::aid_lim_t     lim;
   logic [8:0]            wordIdx;
   logic [1:0]            stageCnt;
   logic                  errAbort;
   logic                  errBit;
   logic                  busWr;
   logic                  busRd;
   logic                  cmdWr;
   logic                  selected;
   logic                  canRun;
   logic                  dataRd;
   logic                  dataReq;
   logic [31:0]           regValue;
   logic [7:0]            statusVal;

   // byte-lane merge for the wide registers
   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction : mergeBytes

   // one identify word by index
   function automatic logic [15:0] identWord(input logic [7:0]        idx,
                                             input aid_pkg::aid_cfg_t c,
                                             input aid_pkg::aid_lim_t l);
      logic [15:0] w;
      logic [8:0]  off;
      w = 16'h0000;
      off = 9'h000;
      if (idx >= 8'd10 && idx <= 8'd19) begin
         off = 9'({idx - 8'd10, 4'h0});
         w = SERIAL_STR[9'd159 - off -: 16]; // R6
      end else if (idx >= 8'd23 && idx <= 8'd26) begin
         off = 9'({idx - 8'd23, 4'h0});
         w = FW_STR[9'd63 - off -: 16]; // R6
      end else if (idx >= 8'd27 && idx <= 8'd46) begin
         off = 9'({idx - 8'd27, 4'h0});
         w = MODEL_STR[9'd319 - off -: 16]; // R6
      end else begin
         case (idx)
            `AID_WI_CLASS: w = c.altClass ? `AID_W0_FIXED_ALT : `AID_W0_FIXED; // R3
            8'd1:          w = DEF_CYLS; // R5
            `AID_WI_SPEC:  w = `AID_W2_SPECCFG; // R4
            8'd3:          w = {8'h00, DEF_HEADS[7:0]}; // R5
            `AID_WI_SPT:   w = `AID_W6_SPT; // R5
            8'd20:         w = `AID_W20_CTRL; // R7
            8'd21:         w = l.bufSectors; // R8
            8'd22:         w = {8'h00, c.eccBytes}; // R9
            `AID_WI_MULTMAX: w = {`AID_W47_HI, l.maxMultiple}; // R10
            8'd49: begin
               w = `AID_W49_BASE; // R11
               w[`AID_W49_STDBY_BIT] = c.stdTimerStd; // R11
            end
            8'd50:         w = {`AID_W50_VALID, 13'h0000, c.stdMinGe5}; // R12
            8'd51:         w = `AID_W51_PIO; // R13
            8'd52:         w = `AID_W52_DMA; // R13
            `AID_WI_VALID: w = `AID_W53_VALID; // R14
            8'd54:         w = DEF_CYLS; // R15
            8'd55:         w = DEF_HEADS; // R15
            8'd56:         w = `AID_W6_SPT; // R15
            8'd57:         w = TOTAL_SECTORS[15:0]; // R15
            8'd58:         w = TOTAL_SECTORS[31:16]; // R15
            `AID_WI_MULT:  w = {7'h00, c.multValid, c.multCount}; // R16
            8'd60:         w = TOTAL_SECTORS[15:0]; // R17
            8'd61:         w = TOTAL_SECTORS[31:16]; // R17
            8'd63:         w = {c.dmaActive, `AID_W63_SUPP}; // R18
            `AID_WI_PIOMODE: w = `AID_W64_PIO; // R19
            8'd65:         w = 16'(`AID_T_DMA_NS); // R20
            8'd66:         w = 16'(`AID_T_DMA_NS); // R20
            `AID_WI_PIOTIME: w = 16'(`AID_T_PIO_NS); // R20
            8'd68:         w = 16'(`AID_T_PIO_IORDY_NS); // R20
            default:       w = 16'h0000;
         endcase
      end
      return w;
   endfunction : identWord

   // reset release through two flops
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // bus strobes and command decode
   always_comb begin
      busWr    = write && !waitrequest;
      busRd    = read && !waitrequest;
      cmdWr    = busWr && (address == `AID_OFF_COMMAND) && byteenable[0]
                 && (state == aid_pkg::AID_IDLE);
      selected = (taskFile.devHead[`AID_DEV_BIT] == DRIVE_NUM); // R1
      canRun   = !cfg.notReady && (writedata[7:0] == `AID_CMD_IDENTIFY); // R1
      dataRd   = busRd && (address == `AID_OFF_DATA) && (state == aid_pkg::AID_XFER);
      dataReq  = read && waitrequest && (address == `AID_OFF_DATA)
                 && (state == aid_pkg::AID_XFER);
   end

   // one wait cycle per access
   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   // status byte
   always_comb begin
      statusVal = 8'h00;
      statusVal[`AID_ST_BSY] = (state == aid_pkg::AID_STAGE); // R21
      statusVal[`AID_ST_RDY] = !cfg.notReady;
      statusVal[`AID_ST_DSC] = !cfg.notReady;
      statusVal[`AID_ST_DRQ] = (state == aid_pkg::AID_XFER); // R21
      statusVal[`AID_ST_ERR] = errBit; // R22
   end

   // register read mux
   always_comb begin
      regValue = 32'h0000_0000;
      case (address)
         `AID_OFF_DATA: begin
            if (state == aid_pkg::AID_XFER) begin
               regValue = {16'h0000, identWord(wordIdx[7:0], cfg, lim)}; // R2
            end
         end
         `AID_OFF_ERROR: regValue = {24'h00_0000, 5'h00, errAbort, 2'h0}; // R22
         `AID_OFF_SECCNT:  regValue = {24'h00_0000, taskFile.secCount};
         `AID_OFF_SECNUM:  regValue = {24'h00_0000, taskFile.secNum};
         `AID_OFF_CYLLO:   regValue = {24'h00_0000, taskFile.cylLow};
         `AID_OFF_CYLHI:   regValue = {24'h00_0000, taskFile.cylHigh};
         `AID_OFF_DEVHEAD: regValue = {24'h00_0000, taskFile.devHead};
         `AID_OFF_COMMAND: regValue = {24'h00_0000, statusVal};
         `AID_OFF_CFG:     regValue = cfg;
         `AID_OFF_LIM:     regValue = lim;
         default:          regValue = 32'h0000_0000;
      endcase
   end

   // read data captured while the request waits
   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         readdata <= 32'h0000_0000;
      end else if (read && waitrequest) begin
         readdata <= regValue;
      end
   end

   // task file writes, ignored while busy
   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         taskFile <= '0;
      end else if (busWr && byteenable[0] && (state == aid_pkg::AID_IDLE)) begin
         case (address)
            `AID_OFF_ERROR:   taskFile.feature  <= writedata[7:0];
            `AID_OFF_SECCNT:  taskFile.secCount <= writedata[7:0];
            `AID_OFF_SECNUM:  taskFile.secNum   <= writedata[7:0];
            `AID_OFF_CYLLO:   taskFile.cylLow   <= writedata[7:0];
            `AID_OFF_CYLHI:   taskFile.cylHigh  <= writedata[7:0];
            `AID_OFF_DEVHEAD: taskFile.devHead  <= writedata[7:0]; // R1
            default:          taskFile.feature  <= taskFile.feature;
         endcase
      end
   end

   // configuration registers
   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         cfg <= `AID_CFG_RST;
         lim <= `AID_LIM_RST;
      end else if (busWr) begin
         if (address == `AID_OFF_CFG) begin
            cfg <= mergeBytes(cfg, writedata, byteenable) & `AID_CFG_MASK; // R9
         end
         if (address == `AID_OFF_LIM) begin
            lim <= mergeBytes(lim, writedata, byteenable) & `AID_LIM_MASK;
         end
      end
   end

   // command sequencer
   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         state    <= aid_pkg::AID_IDLE;
         stageCnt <= 2'h0;
      end else begin
         case (state)
            aid_pkg::AID_IDLE: begin
               stageCnt <= 2'h0;
               if (cmdWr && selected && canRun) begin
                  state <= aid_pkg::AID_STAGE; // R21
               end
            end
            aid_pkg::AID_STAGE: begin
               stageCnt <= stageCnt + 2'h1;
               if (stageCnt == `AID_STAGE_CYCLES - 2'h1) begin
                  state <= aid_pkg::AID_XFER; // R21
               end
            end
            aid_pkg::AID_XFER: begin
               if (dataRd && (wordIdx[7:0] == `AID_LAST_WORD)) begin
                  state <= aid_pkg::AID_IDLE; // R2
               end
            end
            default: state <= aid_pkg::AID_IDLE;
         endcase
      end
   end

   // word pointer through the sector
   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         wordIdx <= 9'h000;
      end else if (state == aid_pkg::AID_STAGE) begin
         wordIdx <= 9'h000;
      end else if (dataRd) begin
         wordIdx <= wordIdx + 9'h001; // R2
      end
   end

   // completion and abort flags
   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         errAbort <= 1'b0;
         errBit   <= 1'b0;
      end else if (cmdWr && selected) begin
         errAbort <= !canRun; // R22
         errBit   <= !canRun; // R22
      end
   end

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstSync);

   a_start_then_drq: assert property ( // R21
      (cmdWr && selected && canRun) |=> (state == aid_pkg::AID_STAGE) [*2]
         ##1 (state == aid_pkg::AID_XFER))
      else $error("identify did not reach data phase after staging");

   a_sector_length: assert property ( // R2
      $fell(state == aid_pkg::AID_XFER) |-> $past(dataRd) && ($past(wordIdx) == 9'h0ff)
         && !errBit)
      else $error("data phase ended away from word 255");

   a_word0_class: assert property ( // R3
      (dataReq && (wordIdx[7:0] == `AID_WI_CLASS))
         |=> (readdata[15:0] == `AID_W0_FIXED) || (readdata[15:0] == `AID_W0_FIXED_ALT))
      else $error("word 0 classification wrong");

   a_word2_spec: assert property ( // R4
      (dataReq && (wordIdx[7:0] == `AID_WI_SPEC)) |=> (readdata[15:0] == `AID_W2_SPECCFG))
      else $error("word 2 specific configuration wrong");

   a_word6_spt: assert property ( // R5
      (dataReq && (wordIdx[7:0] == `AID_WI_SPT)) |=> (readdata[15:0] == `AID_W6_SPT))
      else $error("word 6 sectors per track wrong");

   a_word47_limit: assert property ( // R10
      (dataReq && (wordIdx[7:0] == `AID_WI_MULTMAX))
         |=> (readdata[15:8] == `AID_W47_HI) && (readdata[7:0] == $past(lim.maxMultiple)))
      else $error("word 47 multiple limit wrong");

   a_word53_flags: assert property ( // R14
      (dataReq && (wordIdx[7:0] == `AID_WI_VALID)) |=> (readdata[15:0] == `AID_W53_VALID))
      else $error("word 53 validity flags wrong");

   a_word59_mult: assert property ( // R16
      (dataReq && (wordIdx[7:0] == `AID_WI_MULT))
         |=> (readdata[15:9] == 7'h00) && (readdata[7:0] == $past(cfg.multCount)))
      else $error("word 59 multiple setting wrong");

   a_word64_pio: assert property ( // R19
      (dataReq && (wordIdx[7:0] == `AID_WI_PIOMODE)) |=> (readdata[15:0] == `AID_W64_PIO))
      else $error("word 64 pio modes wrong");

   a_word67_time: assert property ( // R20
      (dataReq && (wordIdx[7:0] == `AID_WI_PIOTIME)) |=> (readdata[15:0] == 16'd240))
      else $error("word 67 pio cycle time wrong");

   a_abort_no_data: assert property ( // R22
      (cmdWr && selected && !canRun)
         |=> errAbort && errBit && (state == aid_pkg::AID_IDLE) ##1 (state != aid_pkg::AID_XFER))
      else $error("aborted command did not flag or started data");

   c_full_sector: cover property (
      (dataRd && (wordIdx[7:0] == `AID_LAST_WORD)) ##1 (state == aid_pkg::AID_IDLE));

   c_abort: cover property (cmdWr && selected && !canRun);

   c_status_busy: cover property (
      (read && waitrequest && (address == `AID_OFF_COMMAND) && (state == aid_pkg::AID_STAGE)));

endmodule : aid_identify_responder

// ==== core/aid_map.svh ====
// register offsets, field positions, reset values and identify word constants
// Function
// R1: host selects drive, writes identify command
// R2: identify returns exactly one sector of words
// R3: word 0 classifies fixed ata drive
// R4: word 2 holds specific configuration code
// R5: words 1,3,6 report default geometry
// R6: serial, firmware, model strings packed as ascii
// R7: word 20 reports controller type
// R8: word 21 reports buffer size in sectors
// R9: word 22 reports selectable ecc byte count
// R10: word 47 holds 80h and multiple limit
// R11: word 49 reports standby and iordy capabilities
// R12: word 50 valid mark and standby minimum
// R13: words 51,52 report pio and dma timing
// R14: word 53 holds three validity flags
// R15: words 54-58 report current geometry and capacity
// R16: word 59 reports current multiple setting
// R17: words 60-61 report user addressable sectors
// R18: word 63 active and supported multiword dma
// R19: word 64 reports pio modes 3, 4
// R20: words 65-68 report cycle times
// R21: busy, then drq, 256 reads, good completion
// R22: unexecutable command sets abort, no data
`ifndef AID_MAP_SVH
`define AID_MAP_SVH

// bus offsets, byte addresses
`define AID_OFF_DATA       6'h00
`define AID_OFF_ERROR      6'h04
`define AID_OFF_SECCNT     6'h08
`define AID_OFF_SECNUM     6'h0c
`define AID_OFF_CYLLO      6'h10
`define AID_OFF_CYLHI      6'h14
`define AID_OFF_DEVHEAD    6'h18
`define AID_OFF_COMMAND    6'h1c
`define AID_OFF_CFG        6'h20
`define AID_OFF_LIM        6'h24

// reset values and writable masks
`define AID_CFG_RST        32'h2800_0200
`define AID_CFG_MASK       32'hffff_1fff
`define AID_LIM_RST        32'h0100_0010
`define AID_LIM_MASK       32'hffff_00ff

// field positions
`define AID_DEV_BIT        4
`define AID_ERR_ABT_BIT    2
`define AID_ST_BSY         7
`define AID_ST_RDY         6
`define AID_ST_DSC         4
`define AID_ST_DRQ         3
`define AID_ST_ERR         0

// command and transfer
`define AID_CMD_IDENTIFY   8'hec
`define AID_LAST_WORD      8'hff
`define AID_STAGE_CYCLES   2'h2

// identify word indices
`define AID_WI_CLASS       8'd0
`define AID_WI_SPEC        8'd2
`define AID_WI_SPT         8'd6
`define AID_WI_MULTMAX     8'd47
`define AID_WI_VALID       8'd53
`define AID_WI_MULT        8'd59
`define AID_WI_PIOMODE     8'd64
`define AID_WI_PIOTIME     8'd67

// identify word contents
`define AID_W0_FIXED       16'h045a
`define AID_W0_FIXED_ALT   16'h045e
`define AID_W2_SPECCFG     16'h37cb
`define AID_W6_SPT         16'h003f
`define AID_W20_CTRL       16'h0003
`define AID_W47_HI         8'h80
`define AID_W49_BASE       16'h0e00
`define AID_W49_STDBY_BIT  13
`define AID_W50_VALID      2'b01
`define AID_W51_PIO        16'h0200
`define AID_W52_DMA        16'h0200
`define AID_W53_VALID      16'h0007
`define AID_W63_SUPP       8'h07
`define AID_W64_PIO        16'h0003
`define AID_T_DMA_NS       120
`define AID_T_PIO_NS       240
`define AID_T_PIO_IORDY_NS 120

`endif

// ==== core/aid_pkg.sv ====
// types shared by the identify responder
package aid_pkg;

   typedef enum logic [2:0] {
      AID_IDLE  = 3'b001,
      AID_STAGE = 3'b010,
      AID_XFER  = 3'b100
   } aid_state_t;

   typedef struct packed {
      logic [7:0] eccBytes;
      logic [7:0] dmaActive;
      logic [2:0] spare;
      logic       notReady;
      logic       altClass;
      logic       stdMinGe5;
      logic       stdTimerStd;
      logic       multValid;
      logic [7:0] multCount;
   } aid_cfg_t;

   typedef struct packed {
      logic [15:0] bufSectors;
      logic [7:0]  spare;
      logic [7:0]  maxMultiple;
   } aid_lim_t;

   typedef struct packed {
      logic [7:0] feature;
      logic [7:0] secCount;
      logic [7:0] secNum;
      logic [7:0] cylLow;
      logic [7:0] cylHigh;
      logic [7:0] devHead;
   } aid_taskfile_t;

endpackage : aid_pkg

// ==== testbench/aid_host_model.sv ====
// host controller model: avalon-mm master for the task file
module aid_host_model (
   // clock
   input  wire logic        clock,
   // avalon-mm master
   output      logic [5:0]  address,
   output      logic        read,
   output      logic        write,
   output      logic [31:0] writedata,
   output      logic [3:0]  byteenable,
   input  wire logic [31:0] readdata,
   input  wire logic        waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      address    = 6'h3c;
      read       = 1'b0;
      write      = 1'b0;
      writedata  = 32'h5a5a_a5a5;
      byteenable = 4'h0;
   end

   // one access, held until waitrequest is sampled low
   task automatic access(input logic wr, input logic [5:0] addr, input logic [31:0] wdata,
                         output logic [31:0] rdata);
      @(posedge clock);
      address    <= addr;
      writedata  <= wdata;
      byteenable <= 4'hf;
      write      <= wr;
      read       <= ~wr;
      @(posedge clock);
      while (waitrequest !== 1'b0) begin
         @(posedge clock);
      end
      rdata = readdata;
      read       <= 1'b0;
      write      <= 1'b0;
      address    <= ~addr;
      writedata  <= ~wdata;
      byteenable <= 4'h0;
   endtask : access
endmodule : aid_host_model

// ==== testbench/tb.sv ====
// self-checking bench for the identify responder
`include "aid_map.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [159:0] SERIAL = "SN0123456789ABCDEFGH";
   localparam logic [63:0]  FW     = "FW 2.10 ";
   localparam logic [319:0] MODEL  = "TEST DISK MODEL";
   localparam logic [15:0]  CYLS   = 16'h3fff;
   localparam logic [15:0]  HEADS  = 16'h0010;
   localparam logic [31:0]  TOTAL  = 32'h00fb_fc10;
   localparam int           LIMIT  = 30000;

   logic              clock;
   logic              reset_n;
   logic [5:0]        address;
   logic              read;
   logic              write;
   logic [31:0]       writedata;
   logic [3:0]        byteenable;
   logic [31:0]       readdata;
   logic              waitrequest;
   logic [31:0]       rdata;
   aid_pkg::aid_cfg_t cfg;
   aid_pkg::aid_lim_t lim;
   int                err_total = 0;
   int                checked = 0;
   int                cycles = 0;

   aid_identify_responder #(
      .DEF_CYLS      (CYLS),
      .DEF_HEADS     (HEADS),
      .TOTAL_SECTORS (TOTAL),
      .DRIVE_NUM     (1'b0),
      .SERIAL_STR    (SERIAL),
      .FW_STR        (FW),
      .MODEL_STR     (MODEL)
   ) uut (
      .clock(clock), .reset_n(reset_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest)
   );

   aid_host_model host (
      .clock(clock), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest)
   );

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_total++;
         conclude();
      end
   end

   function automatic logic [15:0] exp_word(input int i, input aid_pkg::aid_cfg_t c,
                                            input aid_pkg::aid_lim_t l);
      case (i)
         0: return c.altClass ? 16'h045e : 16'h045a;
         1, 54: return CYLS;
         2: return 16'h37cb;
         3, 55: return HEADS;
         6, 56: return 16'h003f;
         20: return 16'h0003;
         21: return l.bufSectors;
         22: return {8'h00, c.eccBytes};
         47: return {8'h80, l.maxMultiple};
         49: return {2'b00, c.stdTimerStd, 13'h0e00};
         50: return {15'h2000, c.stdMinGe5};
         51, 52: return 16'h0200;
         53: return 16'h0007;
         57, 60: return TOTAL[15:0];
         58, 61: return TOTAL[31:16];
         59: return {7'h00, c.multValid, c.multCount};
         63: return {c.dmaActive, 8'h07};
         64: return 16'h0003;
         65, 66, 68: return 16'h0078;
         67: return 16'h00f0;
         default: begin
            if (i >= 10 && i <= 19) return SERIAL[159 - 16 * (i - 10) -: 16];
            if (i >= 23 && i <= 26) return FW[63 - 16 * (i - 23) -: 16];
            if (i >= 27 && i <= 46) return MODEL[319 - 16 * (i - 27) -: 16];
            return 16'h0000;
         end
      endcase
   endfunction : exp_word

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] unused;
      host.access(1'b1, a, d, unused);
   endtask : bus_wr

   task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
      host.access(1'b0, a, 32'h0000_0000, d);
   endtask : bus_rd

   task automatic status_is(input string name, input logic [7:0] exp);
      bus_rd(`AID_OFF_COMMAND, rdata);
      check(name, {24'h0, rdata[7:0] & 8'h89}, {24'h0, exp});
   endtask : status_is

   // full identify run; midCmd issues a command in mid transfer, which must be ignored
   task automatic identify(input logic midCmd);
      int n;
      bus_wr(`AID_OFF_CFG, cfg);
      bus_wr(`AID_OFF_LIM, lim);
      bus_rd(`AID_OFF_CFG, rdata);
      check("cfg", rdata, cfg & 32'hffff_1fff);
      bus_rd(`AID_OFF_LIM, rdata);
      check("lim", rdata, lim & 32'hffff_00ff);
      bus_wr(`AID_OFF_DEVHEAD, 32'h0000_00a0);
      bus_wr(`AID_OFF_COMMAND, 32'h0000_00ec);
      n = 0;
      do begin
         bus_rd(`AID_OFF_COMMAND, rdata);
         n++;
      end while (rdata[3] !== 1'b1 && n < 16);
      check("status drq", {24'h0, rdata[7:0] & 8'h89}, 32'h08);
      for (int i = 0; i < 256; i++) begin
         if (midCmd && i == 128) bus_wr(`AID_OFF_COMMAND, 32'h0000_0050);
         bus_rd(`AID_OFF_DATA, rdata);
         check("word", {16'h0, rdata[15:0]}, {16'h0, exp_word(i, cfg, lim)});
      end
      status_is("status end", 8'h00);
      bus_rd(`AID_OFF_DATA, rdata);
      check("data after", rdata, 32'h0);
      bus_rd(`AID_OFF_ERROR, rdata);
      check("abort clear", {31'h0, rdata[2]}, 32'h0);
      $display("test identify done");
   endtask : identify

   task automatic expect_abort(input logic [7:0] cmd);
      bus_wr(`AID_OFF_DEVHEAD, 32'h0000_00a0);
      bus_wr(`AID_OFF_COMMAND, {24'h0, cmd});
      status_is("abort status", 8'h01);
      bus_rd(`AID_OFF_ERROR, rdata);
      check("abort error", {31'h0, rdata[2]}, 32'h1);
      bus_rd(`AID_OFF_DATA, rdata);
      check("abort data", rdata, 32'h0);
      $display("test abort done");
   endtask : expect_abort

   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   initial begin
      logic [7:0] badCmd [5] = '{8'h50, 8'he7, 8'h00, 8'hff, 8'hed};
      reset_n = 1'b0;
      void'($urandom(63));
      repeat (6) @(posedge clock);
      check("reset wait", {31'h0, waitrequest}, 32'h1);
      check("reset data", readdata, 32'h0);
      reset_n <= 1'b1;
      repeat (3) @(posedge clock);
      bus_rd(`AID_OFF_CFG, rdata);
      check("cfg reset", rdata, 32'h2800_0200);
      bus_rd(`AID_OFF_LIM, rdata);
      check("lim reset", rdata, 32'h0100_0010);
      status_is("idle status", 8'h00);
      $display("test reset done");
      cfg = aid_pkg::aid_cfg_t'(32'hffff_0fff);
      lim = aid_pkg::aid_lim_t'(32'hffff_00ff);
      identify(1'b1);
      cfg = aid_pkg::aid_cfg_t'(32'h0);
      lim = aid_pkg::aid_lim_t'(32'h0);
      identify(1'b0);
      foreach (badCmd[k]) expect_abort(badCmd[k]);
      bus_wr(`AID_OFF_DEVHEAD, 32'h0000_00b0);
      bus_wr(`AID_OFF_COMMAND, 32'h0000_00ec);
      status_is("other drive", 8'h01);
      bus_rd(`AID_OFF_DATA, rdata);
      check("other data", rdata, 32'h0);
      cfg = aid_pkg::aid_cfg_t'(32'h0000_1000);
      bus_wr(`AID_OFF_CFG, cfg);
      expect_abort(8'hec);
      for (int r = 0; r < 2; r++) begin
         cfg = aid_pkg::aid_cfg_t'($urandom & 32'hffff_0fff);
         lim = aid_pkg::aid_lim_t'($urandom);
         identify(r[0]);
      end
      bus_rd(6'h28, rdata);
      check("unmapped", rdata, 32'h0);
      bus_wr(6'h28, 32'hffff_ffff);
      bus_rd(6'h28, rdata);
      check("unmapped wr", rdata, 32'h0);
      $display("test unmapped done");
      conclude();
   end
endmodule : tb
